// file: ltmc_bank.sv
// Register bank for the video output drive swing and the loop-through
// monitor output of a serial-link deserializer.
// Assumes the port-select register lives elsewhere on the same clock, and
// that recovered forward-channel data already arrive on this clock.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps

module ltmc_bank #(
	parameter int DATA_W = 8
) (
	input  wire logic                                    clk,
	input  wire logic                                    rst,
	input  wire ltmc_pkg::ltmc_bus_t                     bus,
	input  wire logic                                    port_select,
	input  wire logic [DATA_W-1:0]                       fwd_data_first,
	input  wire logic [DATA_W-1:0]                       fwd_data_second,
	output logic      [ltmc_pkg::REG_W-1:0]              rdata,
	output logic [ltmc_pkg::NPORT-1:0][ltmc_pkg::SWING_W-1:0]
	                                                     drive_swing_select,
	output ltmc_pkg::ltmc_mon_cfg_t                      mon_cfg,
	output logic      [DATA_W-1:0]                       loop_through_monitor_out,
	output logic                                         select_mismatch
);

	if (DATA_W < 1)
	begin : g_bad_width
		$error("ltmc_bank: DATA_W must be at least 1");
	end

	typedef struct packed {
		logic [ltmc_pkg::NPORT-1:0][ltmc_pkg::REG_W-1:0] lvds;
		ltmc_pkg::ltmc_mon_cfg_t                         cfg;
		logic [ltmc_pkg::REG_W-1:0]                      rdata;
		logic [DATA_W-1:0]                               mon_data;
	} ltmc_state_t;

	ltmc_state_t st;
	ltmc_state_t next_st;
	logic        field_valid;

	// Only the two defined codes name a port
	assign field_valid = (st.cfg.port_field == ltmc_pkg::FIELD_FIRST) ||
		(st.cfg.port_field == ltmc_pkg::FIELD_SECOND);

	always_comb
	begin
		next_st = st;
		next_st.rdata = ltmc_pkg::READ_ZERO;
		if (bus.wr)
		begin
			case (bus.addr)
				ltmc_pkg::ADDR_LVDS_CTL:
					// Every bit is storage; the selected port's copy takes it
					next_st.lvds[port_select] = bus.wdata;
				ltmc_pkg::ADDR_MON_CTL1:
					next_st.cfg.port_bit =
						bus.wdata[ltmc_pkg::ROUTE_BIT];
				ltmc_pkg::ADDR_MON_ENA:
					next_st.cfg.driver_on =
						bus.wdata[ltmc_pkg::DRIVER_BIT];
				ltmc_pkg::ADDR_MON_CTL2:
					next_st.cfg.port_field =
						bus.wdata[ltmc_pkg::FIELD_LSB +: ltmc_pkg::FIELD_W];
				default:
					;
			endcase
		end
		if (bus.rd)
		begin
			case (bus.addr)
				ltmc_pkg::ADDR_LVDS_CTL:
					next_st.rdata = st.lvds[port_select];
				ltmc_pkg::ADDR_MON_CTL1:
					next_st.rdata[ltmc_pkg::ROUTE_BIT] = st.cfg.port_bit;
				ltmc_pkg::ADDR_MON_ENA:
					next_st.rdata[ltmc_pkg::DRIVER_BIT] = st.cfg.driver_on;
				ltmc_pkg::ADDR_MON_CTL2:
					next_st.rdata[ltmc_pkg::FIELD_LSB +: ltmc_pkg::FIELD_W] =
						st.cfg.port_field;
				default:
					next_st.rdata = ltmc_pkg::READ_ZERO;
			endcase
		end
		// Monitor mirrors one input only while driven and a port is named
		next_st.mon_data = '0;
		if (st.cfg.driver_on && field_valid)
		begin
			if (st.cfg.port_bit == ltmc_pkg::ROUTE_SECOND)
				next_st.mon_data = fwd_data_second;
			else
				next_st.mon_data = fwd_data_first;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st.lvds           <= {ltmc_pkg::NPORT{ltmc_pkg::RST_LVDS_CTL}};
			st.cfg.driver_on  <= ltmc_pkg::RST_BIT;
			st.cfg.port_bit   <= ltmc_pkg::RST_BIT;
			st.cfg.port_field <= ltmc_pkg::RST_FIELD;
			st.rdata          <= ltmc_pkg::READ_ZERO;
			st.mon_data       <= '0;
		end
		else
			st <= next_st;
	end

	for (genvar p = 0; p < ltmc_pkg::NPORT; p++)
	begin : g_swing
		assign drive_swing_select[p] =
			st.lvds[p][ltmc_pkg::SWING_LSB +: ltmc_pkg::SWING_W];
	end

	assign rdata                    = st.rdata;
	assign mon_cfg                  = st.cfg;
	assign loop_through_monitor_out = st.mon_data;

	// Flags a field and bit that name different ports
	assign select_mismatch = field_valid &&
		(st.cfg.port_bit !=
		(st.cfg.port_field == ltmc_pkg::FIELD_SECOND));

	// Checks below share the one clock; reset masks them while high
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Bits that the monitor registers keep; every other bit reads zero
	localparam logic [ltmc_pkg::REG_W-1:0] BIT_ONE =
		{{(ltmc_pkg::REG_W-1){1'b0}}, 1'b1};
	localparam logic [ltmc_pkg::REG_W-1:0] MASK_ROUTE =
		BIT_ONE << ltmc_pkg::ROUTE_BIT;
	localparam logic [ltmc_pkg::REG_W-1:0] MASK_DRIVER =
		BIT_ONE << ltmc_pkg::DRIVER_BIT;
	localparam logic [ltmc_pkg::REG_W-1:0] MASK_FIELD =
		{{(ltmc_pkg::REG_W-ltmc_pkg::FIELD_W){1'b0}},
		{ltmc_pkg::FIELD_W{1'b1}}} << ltmc_pkg::FIELD_LSB;
	localparam logic [ltmc_pkg::REG_W-1:0] MASK_LIVE =
		MASK_ROUTE | MASK_DRIVER | MASK_FIELD;

	// A read that carries no write beside it
	sequence s_rd(logic [ltmc_pkg::ADDR_W-1:0] a);
		bus.rd && !bus.wr && bus.addr == a;
	endsequence

	sequence s_wr(logic [ltmc_pkg::ADDR_W-1:0] a);
		bus.wr && bus.addr == a;
	endsequence

	// Write followed at once by a read of the same register
	sequence s_wr_rd(logic [ltmc_pkg::ADDR_W-1:0] a);
		s_wr(a) ##1 s_rd(a);
	endsequence

	// Read of an address that the bank does not map
	sequence s_rd_unmapped;
		bus.rd && !bus.wr &&
		bus.addr != ltmc_pkg::ADDR_LVDS_CTL &&
		bus.addr != ltmc_pkg::ADDR_MON_CTL1 &&
		bus.addr != ltmc_pkg::ADDR_MON_ENA &&
		bus.addr != ltmc_pkg::ADDR_MON_CTL2;
	endsequence

	a_swing_reset: assert property (
		$past(rst) |->
		st.lvds == {ltmc_pkg::NPORT{ltmc_pkg::RST_LVDS_CTL}} &&
		drive_swing_select == '0)
		else $error("drive swing not at reset value");

	a_cfg_reset: assert property (
		$past(rst) |->
		mon_cfg == '0 && rdata == ltmc_pkg::READ_ZERO &&
		loop_through_monitor_out == '0 && !select_mismatch)
		else $error("monitor settings not at reset value");

	for (genvar p = 0; p < ltmc_pkg::NPORT; p++)
	begin : g_swing_chk
		a_swing_write: assert property (
			s_wr(ltmc_pkg::ADDR_LVDS_CTL) and port_select == p |=>
			drive_swing_select[p] ==
			$past(bus.wdata[ltmc_pkg::SWING_LSB +: ltmc_pkg::SWING_W]))
			else $error("drive swing write not stored");
		a_swing_other: assert property (
			s_wr(ltmc_pkg::ADDR_LVDS_CTL) and port_select != p |=>
			$stable(st.lvds[p]))
			else $error("unselected port drive swing changed");
		a_lvds_readback: assert property (
			s_rd(ltmc_pkg::ADDR_LVDS_CTL) and port_select == p |=>
			rdata == $past(st.lvds[p]))
			else $error("drive register readback wrong");
	end

	a_swing_hold: assert property (
		!(bus.wr && bus.addr == ltmc_pkg::ADDR_LVDS_CTL) |=>
		$stable(st.lvds))
		else $error("drive register changed without a write");

	a_route_write: assert property (
		s_wr(ltmc_pkg::ADDR_MON_CTL1) |=>
		mon_cfg.port_bit == $past(bus.wdata[ltmc_pkg::ROUTE_BIT]))
		else $error("route bit write not stored");

	a_route_hold: assert property (
		!(bus.wr && bus.addr == ltmc_pkg::ADDR_MON_CTL1) |=>
		$stable(mon_cfg.port_bit))
		else $error("route bit changed without a write");

	a_driver_write: assert property (
		s_wr(ltmc_pkg::ADDR_MON_ENA) |=>
		mon_cfg.driver_on == $past(bus.wdata[ltmc_pkg::DRIVER_BIT]))
		else $error("driver enable write not stored");

	a_driver_hold: assert property (
		!(bus.wr && bus.addr == ltmc_pkg::ADDR_MON_ENA) |=>
		$stable(mon_cfg.driver_on))
		else $error("driver enable changed without a write");

	a_driver_readback: assert property (
		s_wr_rd(ltmc_pkg::ADDR_MON_ENA) |=>
		rdata == ($past(bus.wdata, 2) & MASK_DRIVER))
		else $error("driver enable readback wrong");

	a_field_write: assert property (
		s_wr(ltmc_pkg::ADDR_MON_CTL2) |=>
		mon_cfg.port_field ==
		$past(bus.wdata[ltmc_pkg::FIELD_LSB +: ltmc_pkg::FIELD_W]))
		else $error("port field write not stored");

	a_field_hold: assert property (
		!(bus.wr && bus.addr == ltmc_pkg::ADDR_MON_CTL2) |=>
		$stable(mon_cfg.port_field))
		else $error("port field changed without a write");

	a_field_readback: assert property (
		s_wr_rd(ltmc_pkg::ADDR_MON_CTL2) |=>
		rdata == ($past(bus.wdata, 2) & MASK_FIELD))
		else $error("port field readback wrong");

	a_reserved_zero: assert property (
		(s_rd(ltmc_pkg::ADDR_MON_CTL1) or
		s_rd(ltmc_pkg::ADDR_MON_ENA) or
		s_rd(ltmc_pkg::ADDR_MON_CTL2)) |=>
		(rdata & ~MASK_LIVE) == ltmc_pkg::READ_ZERO)
		else $error("reserved monitor bits not zero");

	a_unmapped_read: assert property (
		s_rd_unmapped |=>
		rdata == ltmc_pkg::READ_ZERO)
		else $error("unmapped read not zero");

	// Read data stand for the one answer cycle only
	a_idle_rdata: assert property (
		!bus.rd |=>
		rdata == ltmc_pkg::READ_ZERO)
		else $error("read data outside read answer");

	a_monitor_off: assert property (
		!mon_cfg.driver_on |=>
		loop_through_monitor_out == '0)
		else $error("monitor data while driver off");

	a_bad_code: assert property (
		!field_valid |=>
		loop_through_monitor_out == '0)
		else $error("monitor data with unused field code");

	a_route_first: assert property (
		mon_cfg.driver_on && field_valid &&
		mon_cfg.port_bit == ltmc_pkg::PORT_FIRST |=>
		loop_through_monitor_out == $past(fwd_data_first))
		else $error("first input not mirrored");

	a_route_second: assert property (
		mon_cfg.driver_on && field_valid &&
		mon_cfg.port_bit == ltmc_pkg::PORT_SECOND |=>
		loop_through_monitor_out == $past(fwd_data_second))
		else $error("second input not mirrored");

	// The flag names a conflict only between the two defined codes
	a_mismatch_set: assert property (
		(mon_cfg.port_field == ltmc_pkg::FIELD_FIRST &&
		mon_cfg.port_bit == ltmc_pkg::PORT_SECOND) ||
		(mon_cfg.port_field == ltmc_pkg::FIELD_SECOND &&
		mon_cfg.port_bit == ltmc_pkg::PORT_FIRST) |->
		select_mismatch)
		else $error("select mismatch not flagged");

	a_mismatch_clear: assert property (
		(mon_cfg.port_field == ltmc_pkg::FIELD_FIRST &&
		mon_cfg.port_bit == ltmc_pkg::PORT_FIRST) ||
		(mon_cfg.port_field == ltmc_pkg::FIELD_SECOND &&
		mon_cfg.port_bit == ltmc_pkg::PORT_SECOND) ||
		!field_valid |->
		!select_mismatch)
		else $error("select mismatch raised falsely");

endmodule : ltmc_bank

// file: ltmc_pkg.sv
// Constants and carrier types for the loop-through monitor register bank.
// Assumes an 8-bit register address and 8-bit register data.
package ltmc_pkg;

	localparam int NPORT   = 2;
	localparam int ADDR_W  = 8;
	localparam int REG_W   = 8;

	// Register offsets
	localparam logic [ADDR_W-1:0] ADDR_LVDS_CTL = 8'h4b;
	localparam logic [ADDR_W-1:0] ADDR_MON_CTL1 = 8'h52;
	localparam logic [ADDR_W-1:0] ADDR_MON_ENA  = 8'h56;
	localparam logic [ADDR_W-1:0] ADDR_MON_CTL2 = 8'h57;

	// Reset values
	localparam logic [REG_W-1:0] RST_LVDS_CTL = 8'h08;
	localparam logic             RST_BIT      = 1'h0;
	localparam logic [1:0]       RST_FIELD    = 2'h0;
	localparam logic [REG_W-1:0] READ_ZERO    = 8'h00;

	// Field positions
	localparam int SWING_LSB  = 0;
	localparam int SWING_W    = 2;
	localparam int ROUTE_BIT  = 7;
	localparam int DRIVER_BIT = 3;
	localparam int FIELD_LSB  = 1;
	localparam int FIELD_W    = 2;

	// Encodings
	localparam logic [FIELD_W-1:0] FIELD_FIRST  = 2'h1;
	localparam logic [FIELD_W-1:0] FIELD_SECOND = 2'h2;
	localparam logic               ROUTE_SECOND = 1'h1;
	localparam logic               PORT_FIRST   = 1'h0;
	localparam logic               PORT_SECOND  = 1'h1;

	// Register port request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [REG_W-1:0]  wdata;
		logic              wr;
		logic              rd;
	} ltmc_bus_t;

	// Monitor configuration seen by the output path
	typedef struct packed {
		logic               driver_on;
		logic               port_bit;
		logic [FIELD_W-1:0] port_field;
	} ltmc_mon_cfg_t;

endpackage : ltmc_pkg

// file: ltmc_bank_bench.sv
// Self-checking bench for the loop-through monitor register bank.
// Assumes one clock; the bench drives the register port and both inputs.
`timescale 1ns/1ps

module ltmc_bank_bench;
	logic                    clk = 1'b0;
	logic                    rst = 1'b1;
	ltmc_pkg::ltmc_bus_t     bus = '0;
	logic                    port_select = 1'b0;
	logic [7:0]              fwd_first = 8'h00;
	logic [7:0]              fwd_second = 8'h00;
	logic [7:0]              rdata;
	logic [1:0][1:0]         swing;
	ltmc_pkg::ltmc_mon_cfg_t mon_cfg;
	logic [7:0]              mon_out;
	logic                    select_mismatch;
	logic                    mon_req = 1'b0;
	logic                    rd_d = 1'b0;
	logic                    mon_d = 1'b0;
	logic [7:0]              exp_rd[$];
	logic [7:0]              exp_mon[$];
	int                      mismatches = 0;
	int                      cmp_count = 0;
	int                      seed = 69446;
	logic [7:0]              d0, d1;
	logic                    on, b;
	logic [1:0]              f;

	always #20 clk = ~clk;

	ltmc_bank #(.DATA_W(8)) u_dut (
		.clk                      (clk),
		.rst                      (rst),
		.bus                      (bus),
		.port_select              (port_select),
		.fwd_data_first           (fwd_first),
		.fwd_data_second          (fwd_second),
		.rdata                    (rdata),
		.drive_swing_select       (swing),
		.mon_cfg                  (mon_cfg),
		.loop_through_monitor_out (mon_out),
		.select_mismatch          (select_mismatch)
	);

	task check(input string name, input logic [7:0] exp, got);
		cmp_count++;
		if (got !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
			mismatches++;
		end
	endtask : check

	task wr(input logic [7:0] a, d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
	endtask : wr

	task rd(input logic [7:0] a, e);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		exp_rd.push_back(e);
	endtask : rd

	task idle;
		@(posedge clk);
		bus <= '0;
		mon_req <= 1'b0;
	endtask : idle

	// Fresh data on both inputs; note what the monitor must show next cycle
	task smp;
		d0 = 8'($random(seed));
		d1 = 8'($random(seed));
		@(posedge clk);
		bus <= '0;
		fwd_first <= d0;
		fwd_second <= d1;
		mon_req <= 1'b1;
		exp_mon.push_back((on && (f == 2'h1 || f == 2'h2)) ? (b ? d1 : d0) : 8'h00);
	endtask : smp

	task end_sim;
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim

	always @(posedge clk)
	begin
		rd_d <= bus.rd;
		mon_d <= mon_req;
	end

	always @(negedge clk)
	begin
		if (rd_d && exp_rd.size() > 0)
			check("rdata", exp_rd.pop_front(), rdata);
		else if (rd_d)
			mismatches++;
		if (mon_d && exp_mon.size() > 0)
			check("monitor", exp_mon.pop_front(), mon_out);
	end

	initial
	begin
		repeat (5000) @(posedge clk);
		mismatches++;
		end_sim;
	end

	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd(8'h4b, 8'h08);
		rd(8'h52, 8'h00);
		rd(8'h56, 8'h00);
		rd(8'h57, 8'h00);
		rd(8'h60, 8'h00);
		idle;
		@(negedge clk);
		check("swing", 8'h00, {4'h0, swing});
		check("cfg", 8'h00, {4'h0, mon_cfg});
		for (int i = 0; i < 4; i++)
		begin
			d0 = 8'($random(seed));
			d0[1:0] = i[1:0];
			wr(8'h4b, d0);
			rd(8'h4b, d0);
		end
		d1 = 8'($random(seed));
		idle;
		port_select <= 1'b1;
		wr(8'h4b, d1);
		rd(8'h4b, d1);
		idle;
		port_select <= 1'b0;
		rd(8'h4b, d0);
		idle;
		@(negedge clk);
		check("swing", {4'h0, d1[1:0], d0[1:0]}, {4'h0, swing});
		wr(8'h52, 8'hff);
		rd(8'h52, 8'h80);
		wr(8'h56, 8'hff);
		rd(8'h56, 8'h08);
		wr(8'h57, 8'hff);
		rd(8'h57, 8'h06);
		for (int k = 0; k < 16; k++)
		begin
			{on, b, f} = k[3:0];
			wr(8'h56, {4'h0, on, 3'h0});
			wr(8'h52, {b, 7'h00});
			wr(8'h57, {5'h00, f, 1'b0});
			idle;
			@(negedge clk);
			check("cfg", {4'h0, on, b, f}, {4'h0, mon_cfg});
			check("mismatch",
				{7'h00, (f == 2'h1 && b) || (f == 2'h2 && !b)},
				{7'h00, select_mismatch});
			smp;
			smp;
			idle;
		end
		repeat (4) @(posedge clk);
		if (exp_rd.size() != 0 || exp_mon.size() != 0)
			mismatches++;
		end_sim;
	end
endmodule : ltmc_bank_bench
